// file: rtl/gpio_port_defs.svh
// Register map, field positions and reset values of the six-pin port.
// Assumes inclusion by bare name from files that need the constants.
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH

`define OFS_PORT_PIN      8'h00
`define OFS_PIN_DIR       8'h04
`define OFS_INT_CTRL      8'h08
`define OFS_CONFIG        8'h0C
`define OFS_STATUS        8'h10

`define DIR_RESET         8'hFF
`define DIR_EE_MASK       8'hC0
`define PIN_THREE_BIT     3
`define PIN_FOUR_BIT      4
`define PIN_FIVE_BIT      5
`define CHANGE_IE_BIT     3
`define CHANGE_FLAG_BIT   0
`define PULLUP_EN_BIT     7
`define MST_CLEAR_BIT     0
`define CLK_OUT_BIT       1
`define OSC_LSB           2
`define OSC_MSB           4
`define ANALOG_LSB        5
`define ANALOG_MSB        8
`define CFG_RESET         9'h1E0
`define PULLUP_PINS       8'h0B
`define AXI_OKAY          2'h0
`define AXI_SLVERR        2'h2

`endif

// file: rtl/gpio_port_pkg.sv
// Types shared by the six-pin port.
// Assumes nothing of its surroundings.
package gpio_port_pkg;
  typedef enum logic [2:0]
  {
    OSC_LP    = 3'h0,
    OSC_XT    = 3'h1,
    OSC_HS    = 3'h2,
    OSC_INT_RC = 3'h3,
    OSC_EXT_RC = 3'h4
  } osc_mode_t;

  typedef enum logic [1:0]
  {
    WR_IDLE = 2'h0,
    WR_RESP = 2'h1
  } wr_state_t;
endpackage : gpio_port_pkg

// file: rtl/six_pin_gpio_port.sv
// Six-pin port with two internal EEPROM lines, reached over AXI4-Lite.
// Assumes pins and EEPROM lines are asynchronous and pass synchronisers.
// Function
// - Port read returns pin levels, not latches
// - Reset loads direction register all ones
// - Port register eight bits, six external
// - Bit six EEPROM data, seven clock
// - Pin three input only, direction reads one
// - Direction bits six, seven read zero
// - Alternate-function pins read as zero at port, raw at status
// - Pull-ups and change shared on 0,1,3
// - Master clear forces pin three pull-up
// - Master clear: no change event, reads zero
// - Change detection only while enable set
// - External oscillator overrides pins four, five
// - Direction one floats, zero drives latch
// - Direction 5:4 forced one except RC modes
// - Clock output ignores pin four direction
// - Outputs latched, inputs sampled at read
// - Each pin but three own direction
// - After power-on analog pins read zero
// - Port write updates only output latches
`timescale 1ns/10ps
`include "gpio_port_defs.svh"

module six_pin_gpio_port
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  pin_in,
  output logic [7:0]       pin_out,
  output logic [7:0]       pin_oe,
  output logic [7:0]       pin_pullup,
  output logic             change_irq_flag
);

  // Configuration: bit0 master clear, bit1 clock out, 4:2 osc, 8:5 analog
  logic [8:0]  config_r;
  logic [7:0]  port_latch_r;
  logic [7:0]  pin_dir_r;
  logic [7:0]  intctl_r;
  logic [7:0]  sync1_r;
  logic [7:0]  sync2_r;
  logic [7:0]  last_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  gpio_port_pkg::wr_state_t wr_state_r;
  logic        mst_clear_on;
  logic        rc_mode;
  logic        ext_osc;
  logic [7:0]  alt_mask;
  logic [7:0]  port_view;
  logic [7:0]  dir_view;
  logic [7:0]  dir_eff;
  logic [7:0]  changed;
  logic        do_write;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic        wr_lane0;
  logic        wr_lane1;
  logic        flag_clear;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [7:0]  rd_addr;
  gpio_port_pkg::osc_mode_t osc_mode;

  assign osc_mode = gpio_port_pkg::osc_mode_t'(config_r[`OSC_MSB:`OSC_LSB]);
  assign mst_clear_on = config_r[`MST_CLEAR_BIT];
  assign rc_mode  = (osc_mode == gpio_port_pkg::OSC_INT_RC) ||
                    (osc_mode == gpio_port_pkg::OSC_EXT_RC);
  // Crystal modes own both oscillator pins; external RC takes pin five only
  assign ext_osc  = !rc_mode;

  // Pins taken by an alternate function read as zero
  always_comb
  begin
    alt_mask = 8'h00;
    alt_mask[`PIN_THREE_BIT] = mst_clear_on;
    alt_mask[`PIN_FOUR_BIT]  = ext_osc ||
                               (rc_mode && config_r[`CLK_OUT_BIT]);
    alt_mask[`PIN_FIVE_BIT]  = ext_osc ||
                               (osc_mode == gpio_port_pkg::OSC_EXT_RC);
    alt_mask[2:0] = {config_r[`ANALOG_LSB+2], config_r[`ANALOG_LSB+1],
                     config_r[`ANALOG_LSB]};
    alt_mask[`PIN_FOUR_BIT] = alt_mask[`PIN_FOUR_BIT] ||
                              config_r[`ANALOG_MSB];
  end

  // Port read shows synchronised pin levels, not the latches
  assign port_view = sync2_r & ~alt_mask;

  // Direction as software sees it
  always_comb
  begin
    dir_view = pin_dir_r & ~`DIR_EE_MASK;
    dir_view[`PIN_THREE_BIT] = 1'b1;
    if (!rc_mode)
    begin
      dir_view[`PIN_FIVE_BIT:`PIN_FOUR_BIT] = 2'h3;
    end
  end

  // Effective direction, one floats; EEPROM lines keep their own bits
  always_comb
  begin
    dir_eff = dir_view;
    dir_eff[7:6] = pin_dir_r[7:6];
    dir_eff = dir_eff | alt_mask;
    dir_eff[`PIN_THREE_BIT] = 1'b1;
    if (rc_mode && config_r[`CLK_OUT_BIT])
    begin
      dir_eff[`PIN_FOUR_BIT] = 1'b0;
    end
  end

  // Two-flop synchronisers on every pin
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
      last_r  <= 8'h00;
    end
    else
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      last_r  <= sync2_r;
    end
  end

  // Change on shared pins 0, 1, 3; pin three masked under master clear
  assign changed = (sync2_r ^ last_r) & `PULLUP_PINS &
                   ~({7'h00, mst_clear_on} << `PIN_THREE_BIT);

  // Write channel: capture address and data in either order
  assign do_write = aw_held_r && w_held_r &&
                    wr_state_r == gpio_port_pkg::WR_IDLE;
  assign wr_addr  = awaddr_r;
  assign wr_data  = wdata_r;
  assign wr_lane0 = do_write && wstrb_r[0];
  assign wr_lane1 = do_write && wstrb_r[1];

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_OKAY;
      wr_state_r    <= gpio_port_pkg::WR_IDLE;
    end
    else
    begin
      s_axi_awready <= !aw_held_r && !s_axi_awready &&
                       wr_state_r == gpio_port_pkg::WR_IDLE;
      s_axi_wready  <= !w_held_r && !s_axi_wready &&
                       wr_state_r == gpio_port_pkg::WR_IDLE;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr[7:0];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      case (wr_state_r)
        gpio_port_pkg::WR_IDLE:
        begin
          if (do_write)
          begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_addr == `OFS_PORT_PIN ||
                             wr_addr == `OFS_PIN_DIR  ||
                             wr_addr == `OFS_INT_CTRL ||
                             wr_addr == `OFS_CONFIG   ||
                             wr_addr == `OFS_STATUS) ? `AXI_OKAY : `AXI_SLVERR;
            wr_state_r   <= gpio_port_pkg::WR_RESP;
          end
        end
        gpio_port_pkg::WR_RESP:
        begin
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            wr_state_r   <= gpio_port_pkg::WR_IDLE;
          end
        end
        default:
        begin
          wr_state_r <= gpio_port_pkg::WR_IDLE;
        end
      endcase
    end
  end

  // Output latches hold until rewritten; port write touches only them
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      port_latch_r <= 8'h00;
    end
    else if (wr_lane0 && wr_addr == `OFS_PORT_PIN)
    begin
      port_latch_r <= wr_data[7:0];
    end
  end

  // Direction register; RC-gated bits 5:4, pin three fixed
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_dir_r <= `DIR_RESET;
    end
    else if (wr_lane0 && wr_addr == `OFS_PIN_DIR)
    begin
      pin_dir_r[2:0] <= wr_data[2:0];
      pin_dir_r[7:6] <= wr_data[7:6];
      if (rc_mode)
      begin
        pin_dir_r[`PIN_FIVE_BIT:`PIN_FOUR_BIT] <= wr_data[5:4];
      end
    end
  end

  // Interrupt control: enable bit 3, pull-up bit 7, sticky change flag
  assign flag_clear = wr_lane0 && wr_addr == `OFS_INT_CTRL &&
                      !wr_data[`CHANGE_FLAG_BIT];
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      intctl_r <= 8'h00;
    end
    else
    begin
      if (wr_lane0 && wr_addr == `OFS_INT_CTRL)
      begin
        intctl_r[7:1] <= wr_data[7:1];
      end
      // A change in the clearing cycle still sets the flag
      if (intctl_r[`CHANGE_IE_BIT] && |changed)
      begin
        intctl_r[`CHANGE_FLAG_BIT] <= 1'b1;
      end
      else if (flag_clear)
      begin
        intctl_r[`CHANGE_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // Configuration word; power-on leaves analog pins selected
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      config_r <= `CFG_RESET;
    end
    else
    begin
      if (wr_lane0 && wr_addr == `OFS_CONFIG)
      begin
        config_r[7:0] <= wr_data[7:0];
      end
      if (wr_lane1 && wr_addr == `OFS_CONFIG)
      begin
        config_r[8] <= wr_data[8];
      end
    end
  end

  // Pin drivers and pull-ups
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_out         <= 8'h00;
      pin_oe          <= 8'h00;
      pin_pullup      <= 8'h00;
      change_irq_flag <= 1'b0;
    end
    else
    begin
      pin_out <= port_latch_r;
      pin_oe  <= ~dir_eff;
      pin_pullup <= intctl_r[`PULLUP_EN_BIT] ? `PULLUP_PINS : 8'h00;
      if (mst_clear_on)
      begin
        pin_pullup[`PIN_THREE_BIT] <= 1'b1;
      end
      change_irq_flag <= intctl_r[`CHANGE_FLAG_BIT];
    end
  end

  // Read channel: one cycle to answer, held until rready
  assign rd_addr = s_axi_araddr[7:0];
  always_comb
  begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    case (rd_addr)
      `OFS_PORT_PIN: rd_word[7:0] = port_view;
      `OFS_PIN_DIR:  rd_word[7:0] = dir_view;
      `OFS_INT_CTRL: rd_word[7:0] = intctl_r;
      `OFS_CONFIG:   rd_word[8:0] = config_r;
      `OFS_STATUS:   rd_word[7:0] = sync2_r;
      default:       rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AXI_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : six_pin_gpio_port

// file: bench/gpio_port_props.sv
// Checker for the six-pin port: bus answer timing and pin-side limits.
// Assumes it is bound onto the port's top module and sees only its ports.
`timescale 1ns/10ps

module gpio_port_props
(
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Pin limits that hold in every mode
  no_drive_three_a: assert property (!pin_oe[3])
    else $error("pin three output enabled");
  pullup_pins_a: assert property ((pin_pullup & 8'hF4) == 8'h00)
    else $error("pull-up on a pin without one");
  pullup_shared_a: assert property (pin_pullup[0] == pin_pullup[1])
    else $error("pull-ups of pins zero and one differ");
  reset_inputs_a: assert property (!$past(nrst) |-> pin_oe == 8'h00)
    else $error("driver enabled right after reset");

  // Outputs move only in answer to a completed write
  latch_hold_a: assert property ($changed(pin_out) |->
    $past(s_axi_bvalid))
    else $error("output latch changed without a write");
  dir_hold_a: assert property ($changed(pin_oe) |->
    $past(s_axi_bvalid))
    else $error("driver enable changed without a write");

  // Both held one edge after the handshake, answer shows the edge after
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
  b_once_a: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid)
    else $error("write answer repeated");
  r_once_a: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid)
    else $error("read answer repeated");
endmodule : gpio_port_props

bind six_pin_gpio_port gpio_port_props u_props (.*);

// file: bench/pin_board_model.sv
// Board circuitry and EEPROM lines seen from the port's pins.
// Assumes the bench sets which lines the board drives and to what.
`timescale 1ns/10ps

module pin_board_model
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_in
);
  logic [7:0] last_r;

  // Floating lines flip each cycle, so a stale level never passes
  always_ff @(posedge sys_clk)
  begin
    last_r <= pin_in;
  end

  // Device driver wins, then the board, then the weak pull-up
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_pullup[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = ~last_r[i];
    end
  end
endmodule : pin_board_model

// file: bench/six_pin_gpio_port_tb.sv
// Self-checking bench for the six-pin port over AXI4-Lite.
// Assumes bready and rready may stay high for the whole run.
`timescale 1ns/10ps
`include "gpio_port_defs.svh"

module six_pin_gpio_port_tb;
  logic sys_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, change_irq_flag;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup, ext_en, ext_val;
  int          err_count, n_compared;

  six_pin_gpio_port DUT (.*);
  pin_board_model u_board (.*);

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic wrap_up;
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [7:0] ex,
                     input logic [7:0] got);
    n_compared++;
    if (got !== ex)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // Both channels offered together; each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                        output logic [1:0] r);
    logic done;
    done = 1'b0;
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 40 && !done; n++)
    begin
      @(posedge sys_clk);
      done = (s_axi_bvalid === 1'b1);
      r = s_axi_bresp;
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end
    if (!done)
    begin
      err_count++;
      wrap_up();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [7:0] d,
                        output logic [1:0] r);
    logic done;
    done = 1'b0;
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 40 && !done; n++)
    begin
      @(posedge sys_clk);
      done = (s_axi_rvalid === 1'b1);
      {d, r} = {s_axi_rdata[7:0], s_axi_rresp};
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end
    if (!done)
    begin
      err_count++;
      wrap_up();
    end
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("bresp", {6'h00, `AXI_OKAY}, {6'h00, r});
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input string nm,
                        input logic [7:0] ex);
    logic [7:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(nm, ex, d);
  endtask : rd_chk

  // Bounded wait; a flag that never rises ends the run
  task automatic wait_flag;
    for (int n = 0; n < 12 && change_irq_flag !== 1'b1; n++)
      @(posedge sys_clk);
    chk("flag", 8'h01, {7'h00, change_irq_flag});
    if (change_irq_flag !== 1'b1)
      wrap_up();
  endtask : wait_flag

  task automatic reset_state;
    rd_chk(`OFS_PIN_DIR, "dir", 8'h3F);
    rd_chk(`OFS_PORT_PIN, "port", 8'hC8);
    ext_val <= 8'hF7;
    tick(4);
    rd_chk(`OFS_PORT_PIN, "port", 8'hC0);
    chk("oe", 8'h00, pin_oe);
  endtask : reset_state

  task automatic rc_drive;
    wr(`OFS_CONFIG, 8'h0C);
    wr(`OFS_PIN_DIR, 8'h00);
    wr(`OFS_PORT_PIN, 8'h15);
    ext_val <= 8'h00;
    tick(4);
    rd_chk(`OFS_PIN_DIR, "dir", 8'h08);
    chk("oe", 8'hF7, pin_oe);
    chk("out", 8'h15, pin_out & 8'hF7);
    rd_chk(`OFS_PORT_PIN, "port", 8'h15);
    wr(`OFS_CONFIG, 8'h0E);
    wr(`OFS_PIN_DIR, 8'h10);
    tick(3);
    chk("oe clock out", 8'hF7, pin_oe);
    // External RC takes pin five only
    wr(`OFS_CONFIG, 8'h10);
    tick(3);
    chk("oe ext rc", 8'hC7, pin_oe);
  endtask : rc_drive

  task automatic crystal;
    wr(`OFS_CONFIG, 8'h00);
    wr(`OFS_PIN_DIR, 8'h00);
    ext_val <= 8'hFF;
    tick(4);
    rd_chk(`OFS_PIN_DIR, "dir", 8'h38);
    chk("oe", 8'hC7, pin_oe);
    rd_chk(`OFS_PORT_PIN, "port", 8'h0D);
    rd_chk(`OFS_STATUS, "status", 8'h3D);
  endtask : crystal

  task automatic change_irq;
    wr(`OFS_CONFIG, 8'h0C);
    wr(`OFS_PIN_DIR, 8'hFF);
    ext_val <= 8'h00;
    tick(6);
    wr(`OFS_INT_CTRL, 8'h08);
    ext_val <= 8'h04;
    tick(10);
    chk("flag", 8'h00, {7'h00, change_irq_flag});
    ext_val <= 8'h05;
    wait_flag();
    rd_chk(`OFS_INT_CTRL, "intctl", 8'h09);
    wr(`OFS_INT_CTRL, 8'h00);
    ext_val <= 8'h07;
    tick(10);
    chk("flag", 8'h00, {7'h00, change_irq_flag});
    wr(`OFS_INT_CTRL, 8'h80);
    tick(2);
    chk("pullup", 8'h0B, pin_pullup);
  endtask : change_irq

  // Pin three pulled up then driven high; only pin three ever moves
  task automatic mst_clear_pin;
    wr(`OFS_INT_CTRL, 8'h08);
    wr(`OFS_CONFIG, 8'h0D);
    ext_en <= 8'hF7;
    tick(3);
    chk("pullup", 8'h08, pin_pullup);
    ext_en <= 8'hFF;
    ext_val <= 8'h0F;
    tick(10);
    chk("flag", 8'h00, {7'h00, change_irq_flag});
    rd_chk(`OFS_PORT_PIN, "port", 8'h07);
  endtask : mst_clear_pin

  // An unmapped offset is refused on both paths
  task automatic unmapped;
    logic [7:0] d;
    logic [1:0] r;
    axi_rd(8'h20, d, r);
    chk("rresp", {6'h00, `AXI_SLVERR}, {6'h00, r});
    chk("rdata", 8'h00, d);
    axi_wr(8'h20, 8'hFF, r);
    chk("bresp", {6'h00, `AXI_SLVERR}, {6'h00, r});
  endtask : unmapped

  initial
  begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {ext_en, ext_val} = 16'hFFFF;
    {err_count, n_compared} = 64'h0;
    tick(6);
    nrst <= 1'b1;
    tick(2);
    reset_state();
    rc_drive();
    crystal();
    change_irq();
    mst_clear_pin();
    unmapped();
    wrap_up();
  end
endmodule : six_pin_gpio_port_tb
